/* File: hw/monitor_adc_defines.svh */
// Register offsets, field positions, reset values and timing counts of the monitor converter
`ifndef MONITOR_ADC_DEFINES_SVH
`define MONITOR_ADC_DEFINES_SVH

// Register map
`define CTRL_ADDR        8'he4
`define FAULT_ADDR       8'hc0
`define RES_BASE_ADDR    8'hd0
`define RES_SPAN         8'h0c

// Control register fields
`define CTRL_HALT_BIT    0
`define CTRL_SEL_LSB     1
`define CTRL_SEL_MSB     3
`define CTRL_ALERT_BIT   4
`define CTRL_BUSY_BIT    5

// Fault register fields, one bit per channel from the LSB given
`define FAULT_UV_LSB     0
`define FAULT_OV_LSB     2

// Reset values
`define CTRL_HALT_RESET  1'b0
`define CTRL_ALERT_RESET 1'b0
`define CTRL_SEL_RESET   3'h0

// Channel codes
`define LAST_CHANNEL     3'h5

// Conversion timing
`define CLK_PERIOD_NS    100
`define CONV_TIME_NS     1000
`define CONV_CYCLES      8'(((`CONV_TIME_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

`endif

/* File: hw/monitor_adc_pkg.sv */
// Types of the monitor converter control block
package monitor_adc_pkg;

  typedef enum logic [0:0] {
    CONV_IDLE = 1'b0,
    CONV_RUN  = 1'b1
  } conv_state_t;

  typedef enum logic [2:0] {
    CH_OUTPUT_VOLTAGE_1 = 3'b000,
    CH_OUTPUT_VOLTAGE_2 = 3'b001,
    CH_AUXILIARY_1      = 3'b010,
    CH_AUXILIARY_2      = 3'b011,
    CH_CURRENT_SENSE_1  = 3'b100,
    CH_CURRENT_SENSE_2  = 3'b101
  } channel_t;

  typedef struct packed {
    logic prev;
    logic flag;
  } fault_state_t;

  typedef struct packed {
    conv_state_t      mode;
    logic             halt;
    logic             alert_en;
    logic [2:0]       sel;
    logic [7:0]       cnt;
    logic [2:0]       sample_channel;
    logic [5:0][9:0]  result;
    logic [7:0]       rdata;
    logic             alert_n;
  } top_state_t;

endpackage : monitor_adc_pkg

/* File: hw/fault_edge_flag.sv */
// Sticky fault flag set on an input's transition into its fault level
`timescale 1ns/1ps
`default_nettype none

module fault_edge_flag #(
  parameter bit ACTIVE = 1'b1
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic level,
  input  wire logic clear,
  output logic      flag
);
  import monitor_adc_pkg::*;

  fault_state_t cur;
  fault_state_t next_cur;

  always_comb begin
    next_cur      = cur;
    next_cur.prev = level;
    if (clear) begin
      next_cur.flag = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (level == ACTIVE && cur.prev != ACTIVE) begin
      next_cur.flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur.prev <= ~ACTIVE;
      cur.flag <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign flag = cur.flag;

endmodule : fault_edge_flag

`default_nettype wire

/* File: hw/monitor_adc_control.sv */
// Monitor converter control, result registers and input fault flags
`timescale 1ns/1ps
`default_nettype none

`include "monitor_adc_defines.svh"

module monitor_adc_control (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [1:0]  undervoltage_input,
  input  wire logic [1:0]  overvoltage_input,
  input  wire logic [9:0]  sample_data,
  output logic      [2:0]  sample_channel,
  output logic             alert_n
);
  import monitor_adc_pkg::*;

  top_state_t  cur;
  top_state_t  next_cur;
  logic [1:0]  uv_flag;
  logic [1:0]  ov_flag;
  logic        ctrl_wr;
  logic        fault_wr;
  logic        res_hit;
  logic [7:0]  res_off;
  logic [2:0]  res_idx;
  logic        res_low;
  logic        single_req;
  logic        busy;
  logic [2:0]  chan_after;
  logic [7:0]  rd_mux;
  logic [7:0]  ctrl_word;
  logic [7:0]  fault_word;
  logic [7:0]  res_word;
  logic        res_wr;
  logic [2:0]  wr_sel;
  logic        conv_done;
  logic        halt_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  assign ctrl_wr    = reg_wr && (reg_addr == `CTRL_ADDR);
  assign fault_wr   = reg_wr && (reg_addr == `FAULT_ADDR);
  assign res_off    = reg_addr - `RES_BASE_ADDR;
  assign res_hit    = (reg_addr >= `RES_BASE_ADDR) && (res_off < `RES_SPAN);
  assign res_idx    = res_off[3:1];
  assign res_low    = res_off[0];
  assign wr_sel     = reg_wdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
  assign single_req = ctrl_wr && reg_wdata[`CTRL_HALT_BIT]
                      && (wr_sel <= `LAST_CHANNEL);
  assign busy       = (cur.mode == CONV_RUN) || !cur.halt;
  assign chan_after = (cur.sample_channel == `LAST_CHANNEL) ? 3'h0 : cur.sample_channel + 3'h1;
  assign res_wr     = reg_wr && res_hit && cur.halt;
  // Last counted cycle of a running conversion
  assign conv_done  = (cur.mode == CONV_RUN) && (cur.cnt == 8'h01);
  assign halt_rise  = ctrl_wr && reg_wdata[`CTRL_HALT_BIT] && !cur.halt;

  ////////////////////////////////////////////////////////////////////////////
  // Input fault flags; a written zero clears a flag

  for (genvar ch = 0; ch < 2; ch++) begin : g_fault
    fault_edge_flag #(
      .ACTIVE (1'b0)
    ) u_uv (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .level   (undervoltage_input[ch]),
      .clear   (fault_wr && !reg_wdata[`FAULT_UV_LSB + ch]),
      .flag    (uv_flag[ch])
    );

    fault_edge_flag #(
      .ACTIVE (1'b1)
    ) u_ov (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .level   (overvoltage_input[ch]),
      .clear   (fault_wr && !reg_wdata[`FAULT_OV_LSB + ch]),
      .flag    (ov_flag[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Reserved control bits stay zero
  always_comb begin
    ctrl_word                              = 8'h00;
    ctrl_word[`CTRL_HALT_BIT]              = cur.halt;
    ctrl_word[`CTRL_SEL_MSB:`CTRL_SEL_LSB] = cur.sel;
    ctrl_word[`CTRL_ALERT_BIT]             = cur.alert_en;
    ctrl_word[`CTRL_BUSY_BIT]              = busy;
  end

  always_comb begin
    fault_word                     = 8'h00;
    fault_word[`FAULT_UV_LSB +: 2] = uv_flag;
    fault_word[`FAULT_OV_LSB +: 2] = ov_flag;
  end

  // Index is only meaningful on a result hit
  always_comb begin
    res_word = 8'h00;
    if (res_hit && res_low) begin
      res_word[7:6] = cur.result[res_idx][1:0];
    end else if (res_hit) begin
      res_word = cur.result[res_idx][9:2];
    end
  end

  // Unmapped addresses read zero
  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr == `CTRL_ADDR) begin
      rd_mux = ctrl_word;
    end else if (reg_addr == `FAULT_ADDR) begin
      rd_mux = fault_word;
    end else if (res_hit) begin
      rd_mux = res_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, converter sequencing and result storage

  always_comb begin
    next_cur = cur;

    if (reg_rd) begin
      next_cur.rdata = rd_mux;
    end

    if (ctrl_wr) begin
      next_cur.halt     = reg_wdata[`CTRL_HALT_BIT];
      next_cur.sel      = wr_sel;
      next_cur.alert_en = reg_wdata[`CTRL_ALERT_BIT];
      next_cur.alert_n  = 1'b1;
    end

    // Host result writes only while halted
    if (res_wr) begin
      if (res_low) begin
        next_cur.result[res_idx][1:0] = reg_wdata[7:6];
      end else begin
        next_cur.result[res_idx][9:2] = reg_wdata;
      end
    end

    unique case (cur.mode)
      CONV_IDLE: begin
        if (single_req) begin
          next_cur.mode           = CONV_RUN;
          next_cur.cnt            = `CONV_CYCLES;
          next_cur.sample_channel = reg_wdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
        end else if (!next_cur.halt) begin
          next_cur.mode = CONV_RUN;
          next_cur.cnt  = `CONV_CYCLES;
        end
      end
      CONV_RUN: begin
        if (single_req) begin
          next_cur.cnt            = `CONV_CYCLES;
          next_cur.sample_channel = reg_wdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
        end else if (halt_rise) begin
          next_cur.mode = CONV_IDLE;
        end else if (conv_done) begin
          // Completion wins over a host write of the same result
          next_cur.result[cur.sample_channel] = sample_data;
          if (cur.alert_en) begin
            next_cur.alert_n = 1'b0;
          end
          if (cur.halt) begin
            next_cur.mode = CONV_IDLE;
          end else begin
            next_cur.cnt            = `CONV_CYCLES;
            next_cur.sample_channel = chan_after;
          end
        end else begin
          next_cur.cnt = cur.cnt - 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur          <= '0;
      cur.mode     <= CONV_IDLE;
      cur.halt     <= `CTRL_HALT_RESET;
      cur.alert_en <= `CTRL_ALERT_RESET;
      cur.sel      <= `CTRL_SEL_RESET;
      cur.alert_n  <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata      = cur.rdata;
  assign sample_channel = cur.sample_channel;
  assign alert_n        = cur.alert_n;

endmodule : monitor_adc_control

`default_nettype wire

/* File: verif/monitor_adc_control_chk.sv */
// Port assertions of the monitor converter control
`timescale 1ns/1ps
`default_nettype none
module monitor_adc_control_chk (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] undervoltage_input,
  input wire logic [1:0] overvoltage_input,
  input wire logic [2:0] sample_channel,
  input wire logic       alert_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic ctl_rd = reg_rd && reg_addr == 8'he4;
  wire logic flt_rd = reg_rd && reg_addr == 8'hc0;
  wire logic flt_wr = reg_wr && reg_addr == 8'hc0;
  wire logic ctl_wr = reg_wr && reg_addr == 8'he4;
  logic      uv0_prev, uv0_seen, ov1_prev, ov1_seen;
  // Expected flags: set on the fault edge, cleared by a written zero, set wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uv0_prev <= 1'b1;
      ov1_prev <= 1'b0;
      uv0_seen <= 1'b0;
      ov1_seen <= 1'b0;
    end else begin
      uv0_prev <= undervoltage_input[0];
      ov1_prev <= overvoltage_input[1];
      uv0_seen <= (flt_wr ? reg_wdata[0] && uv0_seen : uv0_seen) || (uv0_prev && !undervoltage_input[0]);
      ov1_seen <= (flt_wr ? reg_wdata[3] && ov1_seen : ov1_seen) || (!ov1_prev && overvoltage_input[1]);
    end
  end
  AST_UNDER_FLAG: assert property (flt_rd |=> reg_rdata[0] == $past(uv0_seen))
    else $error("under flag wrong");
  AST_OVER_FLAG: assert property (flt_rd |=> reg_rdata[3] == $past(ov1_seen))
    else $error("over flag wrong");
  AST_LOW_RESV: assert property (reg_rd && reg_addr[0] && reg_addr > 8'hd0 && reg_addr < 8'hdc
    |=> reg_rdata[5:0] == 6'h00) else $error("low byte reserved set");
  AST_CTRL_RESV: assert property (ctl_rd |=> reg_rdata[7:6] == 2'h0) else $error("ctrl reserved set");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == 8'h00)
    else $error("unmapped read nonzero");
  AST_BUSY_FREE: assert property (ctl_rd |=> reg_rdata[0] || reg_rdata[5]) else $error("busy low in free run");
  AST_ALERT_HOLD: assert property (!alert_n && !ctl_wr |=> !alert_n) else $error("alert released");
  AST_CHAN_RANGE: assert property (sample_channel <= 3'h5) else $error("channel code out of range");
  cover property ($fell(alert_n));
  cover property (ctl_rd ##1 reg_rdata[0]);
  cover property ($rose(overvoltage_input[1]));
endmodule : monitor_adc_control_chk
bind monitor_adc_control monitor_adc_control_chk chk_u (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .undervoltage_input, .overvoltage_input, .sample_channel, .alert_n);
`default_nettype wire

/* File: verif/sample_source.sv */
// Converter front end: a fixed sample per channel
`timescale 1ns/1ps
`default_nettype none
module sample_source (
  input  wire logic [2:0] sample_channel,
  output logic      [9:0] sample_data
);
  assign sample_data = {sample_channel, 7'h59};
endmodule : sample_source
`default_nettype wire

/* File: verif/monitor_adc_control_tb.sv */
// Self-checking bench of the monitor converter control
`timescale 1ns/1ps
`default_nettype none
module monitor_adc_control_tb;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, alert_n;
  logic [1:0] under_in = 2'h3, over_in = 2'h0;
  logic [9:0] sample_data;
  logic [2:0] sample_channel;
  int         failures = 0, samples_checked = 0, cycles = 0;
  monitor_adc_control dut_u (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .undervoltage_input(under_in), .overvoltage_input(over_in), .sample_data, .sample_channel, .alert_n);
  sample_source src_u (.sample_channel, .sample_data);
  initial forever #50 sys_clk = ~sys_clk;
  task automatic give_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk(exp, reg_rdata);
  endtask : rd
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    rd(8'he4, 8'h20);
    rd(8'h10, 8'h00);
    repeat (80) @(negedge sys_clk);
    for (int c = 0; c < 6; c++) begin
      rd(8'hd0 + 8'(2 * c), {c[2:0], 5'h16});
      rd(8'hd1 + 8'(2 * c), 8'h40);
    end
    $display("free run test done");
    wr(8'he4, 8'hc1);
    repeat (14) @(negedge sys_clk);
    rd(8'he4, 8'h01);
    chk(8'h01, {7'h00, alert_n});
    wr(8'hd4, 8'ha5);
    wr(8'hd5, 8'hff);
    rd(8'hd4, 8'ha5);
    rd(8'hd5, 8'hc0);
    $display("halt test done");
    for (int c = 0; c < 6; c++) begin
      wr(8'he4, 8'h11 | 8'(2 * c));
      repeat (14) @(negedge sys_clk);
      chk(8'h00, {7'h00, alert_n});
      chk(8'(c), {5'h00, sample_channel});
      rd(8'he4, 8'h11 | 8'(2 * c));
      rd(8'hd0 + 8'(2 * c), {c[2:0], 5'h16});
    end
    wr(8'he4, 8'h1d);
    rd(8'he4, 8'h1d);
    chk(8'h01, {7'h00, alert_n});
    $display("single shot test done");
    under_in = 2'h2;
    over_in = 2'h2;
    repeat (2) @(negedge sys_clk);
    rd(8'hc0, 8'h09);
    wr(8'hc0, 8'h00);
    rd(8'hc0, 8'h00);
    under_in = 2'h0;
    over_in = 2'h3;
    repeat (2) @(negedge sys_clk);
    rd(8'hc0, 8'h06);
    $display("fault test done");
    give_verdict();
  end
endmodule : monitor_adc_control_tb
`default_nettype wire
